// *** include/gsam_pkg.sv ***
// gsam_pkg: constants, field layouts and carrier types of the genset anomaly manager.
// assumes a single 40 MHz clock and a plain word-addressed register port.
package gsam_pkg;

   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned TICK_NS = 1000000;
   localparam int unsigned TICK_CYCLES_DEF = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned NUM_DIN = 8;
   localparam int unsigned NUM_AIN = 2;
   localparam int unsigned NUM_THR = 2 * NUM_AIN;
   localparam int unsigned NUM_GEN = 4;
   localparam int unsigned NUM_SRC = NUM_DIN + NUM_THR + NUM_GEN;
   localparam int unsigned SRC_AIN0 = NUM_DIN;
   localparam int unsigned SRC_GEN0 = NUM_DIN + NUM_THR;

   // register word addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_OIL_DLY = 8'h01;
   localparam logic [7:0] REG_ACTIVE = 8'h02;
   localparam logic [7:0] REG_SUMMARY = 8'h03;
   localparam logic [7:0] REG_GEN_THR0 = 8'h04;
   localparam logic [7:0] REG_GEN_DLY0 = 8'h08;
   localparam logic [7:0] REG_DIN_CFG0 = 8'h10;
   localparam logic [7:0] REG_DIN_DLY0 = 8'h18;
   localparam logic [7:0] REG_AIN_THR0 = 8'h20;
   localparam logic [7:0] REG_AIN_CFG0 = 8'h24;

   // control bits
   localparam int unsigned CTRL_DRIVE_BIT = 0;
   localparam int unsigned CTRL_ASYNC_BIT = 1;
   localparam int unsigned CTRL_MAN_EN_BIT = 2;
   localparam int unsigned CTRL_W = 3;

   // digital input slot configuration fields
   localparam int unsigned DCFG_FUNC_LSB = 0;
   localparam int unsigned DCFG_FUNC_W = 13;
   localparam int unsigned DCFG_SRC_LSB = 13;
   localparam int unsigned DCFG_SRC_W = 3;
   localparam int unsigned DCFG_IDX_LSB = 16;
   localparam int unsigned DCFG_IDX_W = 8;
   localparam int unsigned DCFG_W = 24;

   // analogue threshold configuration fields
   localparam int unsigned ACFG_HIGH_BIT = 16;
   localparam int unsigned ACFG_OVR_E_BIT = 17;
   localparam int unsigned ACFG_W = 18;

   localparam int unsigned DLY_W = 16;
   localparam int unsigned MEAS_W = 16;
   localparam int unsigned CODE_W = 10;

   // input function codes (decimal values)
   localparam logic [12:0] FUNC_GENERIC_BASE = 13'h0FA0;
   localparam logic [12:0] FUNC_SPECIFIC_BASE = 13'h1073;
   localparam logic [3:0] GRP_NONE = 4'h0;
   localparam logic [3:0] GRP_OIL = 4'h1;
   localparam logic [3:0] GRP_BREAKER = 4'h2;
   localparam logic [3:0] GRP_FUEL = 4'h3;
   localparam logic [3:0] GRP_GAS = 4'h4;
   localparam logic [3:0] GRP_PUMP = 4'h5;
   localparam logic [3:0] GRP_OVR = 4'h6;

   // anomaly code bases
   localparam logic [9:0] CODE_DIN_PHYS = 10'h2BD;
   localparam logic [9:0] CODE_DIN_AIN = 10'h2D1;
   localparam logic [9:0] CODE_DIN_VIRT = 10'h2D7;
   localparam logic [9:0] CODE_DIN_EXPLO = 10'h2E7;
   localparam logic [9:0] CODE_DIN_EXPHI = 10'h2AD;
   localparam logic [9:0] CODE_AIN_BASE = 10'h12D;
   localparam logic [9:0] CODE_MIN_V = 10'h001;
   localparam logic [9:0] CODE_MAX_V = 10'h002;
   localparam logic [9:0] CODE_MIN_F = 10'h003;
   localparam logic [9:0] CODE_MAX_F = 10'h004;
   // base for specific anomaly codes; value is arbitrary
   localparam logic [9:0] CODE_SPECIFIC_BASE = 10'h384;

   // override eligibility mask bits
   localparam logic [2:0] OVR_E = 3'h1;
   localparam logic [2:0] OVR_F = 3'h2;
   localparam logic [2:0] OVR_G = 3'h4;

   typedef enum logic [1:0] {
      GSAM_WARNING = 2'h0,
      GSAM_DEACT = 2'h1,
      GSAM_UNLOAD = 2'h3,
      GSAM_ALARM = 2'h2
   } gsam_class_e;

   typedef struct packed {
      logic engine_running;
      logic started_by_dev;
      logic breaker_closed;
      logic fuel_open;
      logic gas_open;
      logic ride_through;
      logic vf_ok;
      logic manual_mode;
      logic ovr_engine;
      logic ovr_full;
      logic ovr_generator;
   } gsam_status_s;

   typedef struct packed {
      logic [MEAS_W-1:0] v_min;
      logic [MEAS_W-1:0] v_max;
      logic [MEAS_W-1:0] freq;
      logic [NUM_AIN-1:0][MEAS_W-1:0] ain;
   } gsam_meas_s;

   typedef struct packed {
      logic valid;
      logic [CODE_W-1:0] code;
      gsam_class_e cls;
      logic high_marker;
      logic builtin_msg;
   } gsam_report_s;

endpackage : gsam_pkg

// *** core/gsam_core.sv ***
// gsam_core: turns input, analogue and generator states into coded anomalies.
// assumes status pins and digital inputs are asynchronous, measurements come
// from same-clock logic, and lowest/highest phase voltage is already selected.
`timescale 1ns/10ps

module gsam_core
   import gsam_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [NUM_DIN-1:0] din_pin,
   input wire gsam_status_s status_pin,
   input wire gsam_meas_s meas,
   output logic [NUM_SRC-1:0] anomaly_active,
   output gsam_report_s report,
   output logic any_warning,
   output logic any_deact,
   output logic any_unload,
   output logic any_alarm,
   output logic fuel_pump_stop
);

   localparam int unsigned ST_W = $bits(gsam_status_s);
   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

   // configuration registers
   logic [CTRL_W-1:0] ctrl_q;
   logic [DLY_W-1:0] oil_dly_q;
   logic [NUM_GEN-1:0][MEAS_W-1:0] gen_thr_q;
   logic [NUM_GEN-1:0][DLY_W-1:0] gen_dly_q;
   logic [NUM_DIN-1:0][DCFG_W-1:0] din_cfg_q;
   logic [NUM_DIN-1:0][DLY_W-1:0] din_dly_q;
   logic [NUM_THR-1:0][MEAS_W-1:0] ain_thr_q;
   logic [NUM_THR-1:0][ACFG_W-1:0] ain_cfg_q;

   // synchronisers
   logic [NUM_DIN-1:0] din_s1_q, din_s2_q;
   logic [ST_W-1:0] st_s1_q, st_s2_q;
   gsam_status_s st;

   // timing
   logic [31:0] tick_cnt_q;
   logic tick_q;
   logic [DLY_W-1:0] run_time_q;
   logic vf_seen_q;

   // per-source decode
   logic [NUM_SRC-1:0] cond, armed, builtin, high_mk, pump_grp;
   logic [NUM_SRC-1:0][DLY_W-1:0] dly;
   logic [NUM_SRC-1:0][CODE_W-1:0] code;
   logic [NUM_SRC-1:0][1:0] cls;
   logic [NUM_SRC-1:0][2:0] ovr_mask;
   logic [NUM_SRC-1:0][DLY_W-1:0] cnt_q;
   logic [NUM_SRC-1:0] active_q;
   logic [NUM_SRC-1:0] active_dly_q;
   logic [NUM_SRC-1:0] pending_q;
   logic [NUM_SRC-1:0][1:0] eff_cls;
   logic [2:0] ovr_req;

   assign st = gsam_status_s'(st_s2_q);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         din_s1_q <= '0;
         din_s2_q <= '0;
         st_s1_q <= '0;
         st_s2_q <= '0;
      end else begin
         din_s1_q <= din_pin;
         din_s2_q <= din_s1_q;
         st_s1_q <= status_pin;
         st_s2_q <= st_s1_q;
      end
   end

   // register writes
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= '0;
         oil_dly_q <= '0;
         gen_thr_q <= '0;
         gen_dly_q <= '0;
         din_cfg_q <= '0;
         din_dly_q <= '0;
         ain_thr_q <= '0;
         ain_cfg_q <= '0;
      end else if (reg_wr) begin
         if (reg_addr == REG_CTRL) begin
            ctrl_q <= reg_wdata[CTRL_W-1:0];
         end
         if (reg_addr == REG_OIL_DLY) begin
            oil_dly_q <= reg_wdata[DLY_W-1:0];
         end
         for (int i = 0; i < NUM_GEN; i++) begin
            if (reg_addr == REG_GEN_THR0 + 8'(i)) begin
               gen_thr_q[i] <= reg_wdata[MEAS_W-1:0];
            end
            if (reg_addr == REG_GEN_DLY0 + 8'(i)) begin
               gen_dly_q[i] <= reg_wdata[DLY_W-1:0];
            end
         end
         for (int i = 0; i < NUM_DIN; i++) begin
            if (reg_addr == REG_DIN_CFG0 + 8'(i)) begin
               din_cfg_q[i] <= reg_wdata[DCFG_W-1:0];
            end
            if (reg_addr == REG_DIN_DLY0 + 8'(i)) begin
               din_dly_q[i] <= reg_wdata[DLY_W-1:0];
            end
         end
         for (int i = 0; i < NUM_THR; i++) begin
            if (reg_addr == REG_AIN_THR0 + 8'(i)) begin
               ain_thr_q[i] <= reg_wdata[MEAS_W-1:0];
            end
            if (reg_addr == REG_AIN_CFG0 + 8'(i)) begin
               ain_cfg_q[i] <= reg_wdata[ACFG_W-1:0];
            end
         end
      end
   end

   // register reads: data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
               reg_rdata <= DATA_W'(ctrl_q);
            end
            if (reg_addr == REG_OIL_DLY) begin
               reg_rdata <= DATA_W'(oil_dly_q);
            end
            if (reg_addr == REG_ACTIVE) begin
               reg_rdata <= DATA_W'(active_q);
            end
            if (reg_addr == REG_SUMMARY) begin
               reg_rdata <= {27'h0000000, fuel_pump_stop, any_alarm, any_unload,
                             any_deact, any_warning};
            end
            for (int i = 0; i < NUM_GEN; i++) begin
               if (reg_addr == REG_GEN_THR0 + 8'(i)) begin
                  reg_rdata <= DATA_W'(gen_thr_q[i]);
               end
               if (reg_addr == REG_GEN_DLY0 + 8'(i)) begin
                  reg_rdata <= DATA_W'(gen_dly_q[i]);
               end
            end
            for (int i = 0; i < NUM_DIN; i++) begin
               if (reg_addr == REG_DIN_CFG0 + 8'(i)) begin
                  reg_rdata <= DATA_W'(din_cfg_q[i]);
               end
               if (reg_addr == REG_DIN_DLY0 + 8'(i)) begin
                  reg_rdata <= DATA_W'(din_dly_q[i]);
               end
            end
            for (int i = 0; i < NUM_THR; i++) begin
               if (reg_addr == REG_AIN_THR0 + 8'(i)) begin
                  reg_rdata <= DATA_W'(ain_thr_q[i]);
               end
               if (reg_addr == REG_AIN_CFG0 + 8'(i)) begin
                  reg_rdata <= DATA_W'(ain_cfg_q[i]);
               end
            end
         end
      end
   end

   // delay time base: delays count whole ticks, so a trip lands up to one tick early
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tick_cnt_q == TICK_LAST);
         tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 32'h00000001;
      end
   end

   // engine running time and first good voltage/frequency, both reset on stop
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         run_time_q <= '0;
         vf_seen_q <= 1'b0;
      end else if (!st.engine_running) begin
         run_time_q <= '0;
         vf_seen_q <= 1'b0;
      end else begin
         if (tick_q && run_time_q != '1) begin
            run_time_q <= run_time_q + 16'h0001;
         end
         if (st.vf_ok) begin
            vf_seen_q <= 1'b1;
         end
      end
   end

   assign ovr_req = {st.ovr_generator, st.ovr_full, st.ovr_engine};

   // digital input slots
   for (genvar i = 0; i < NUM_DIN; i++) begin : g_din
      logic [12:0] func, rel, tens, units;
      logic specific, valid;
      logic [9:0] base;
      assign func = din_cfg_q[i][DCFG_FUNC_LSB +: DCFG_FUNC_W];
      assign specific = (func >= FUNC_SPECIFIC_BASE);
      assign rel = func - FUNC_GENERIC_BASE;
      assign tens = rel / 13'h000A;
      assign units = rel % 13'h000A;
      assign valid = specific || (func >= FUNC_GENERIC_BASE && units >= 13'h0001 &&
                     units <= 13'h0004 && tens <= 13'(GRP_OVR) &&
                     !(tens == 13'(GRP_OVR) && units == 13'h0001));
      always_comb begin
         case (din_cfg_q[i][DCFG_SRC_LSB +: DCFG_SRC_W])
            3'h0: base = CODE_DIN_PHYS;
            3'h1: base = CODE_DIN_AIN;
            3'h2: base = CODE_DIN_VIRT;
            3'h3: base = CODE_DIN_EXPLO;
            3'h4: base = CODE_DIN_EXPHI;
            default: base = CODE_DIN_PHYS;
         endcase
      end
      always_comb begin
         armed[i] = valid;
         ovr_mask[i] = 3'h0;
         pump_grp[i] = 1'b0;
         if (!specific) begin
            case (tens[3:0])
               GRP_NONE: armed[i] = valid;
               GRP_OIL: begin
                  armed[i] = valid && st.started_by_dev && st.engine_running &&
                             run_time_q >= oil_dly_q;
                  ovr_mask[i] = OVR_E;
               end
               GRP_BREAKER: armed[i] = valid && st.breaker_closed;
               GRP_FUEL: armed[i] = valid && st.fuel_open;
               GRP_GAS: armed[i] = valid && st.gas_open;
               GRP_PUMP: pump_grp[i] = 1'b1;
               GRP_OVR: ovr_mask[i] = OVR_F;
               default: armed[i] = 1'b0;
            endcase
         end
      end
      assign cond[i] = din_s2_q[i];
      assign dly[i] = din_dly_q[i];
      assign builtin[i] = specific;
      assign high_mk[i] = 1'b0;
      assign code[i] = specific ? CODE_SPECIFIC_BASE + 10'(func - FUNC_SPECIFIC_BASE)
                                : base + 10'(din_cfg_q[i][DCFG_IDX_LSB +: DCFG_IDX_W]);
      assign cls[i] = specific ? GSAM_ALARM : units[1:0] - 2'h1 == 2'h0 ? GSAM_WARNING :
                      units[1:0] == 2'h2 ? GSAM_DEACT :
                      units[1:0] == 2'h3 ? GSAM_UNLOAD : GSAM_ALARM;
   end

   // analogue thresholds: two per input, each with a code of its own
   for (genvar k = 0; k < NUM_THR; k++) begin : g_ain
      logic hi;
      logic [MEAS_W-1:0] val;
      assign hi = ain_cfg_q[k][ACFG_HIGH_BIT];
      assign val = meas.ain[k / 2];
      assign cond[SRC_AIN0 + k] = hi ? (val > ain_thr_q[k]) : (val < ain_thr_q[k]);
      assign armed[SRC_AIN0 + k] = 1'b1;
      assign dly[SRC_AIN0 + k] = ain_cfg_q[k][DLY_W-1:0];
      assign high_mk[SRC_AIN0 + k] = hi;
      assign builtin[SRC_AIN0 + k] = 1'b0;
      assign pump_grp[SRC_AIN0 + k] = 1'b0;
      // even code for the first threshold, odd for the second
      assign code[SRC_AIN0 + k] = CODE_AIN_BASE + 10'((k / 2) * 2) +
                                  ((k % 2 == 0) ? 10'h001 : 10'h000);
      assign cls[SRC_AIN0 + k] = GSAM_ALARM;
      assign ovr_mask[SRC_AIN0 + k] = ain_cfg_q[k][ACFG_OVR_E_BIT] ? OVR_E : 3'h0;
   end

   // generator protections
   logic gen_inh, man_open_inh;
   assign gen_inh = ctrl_q[CTRL_DRIVE_BIT] || ctrl_q[CTRL_ASYNC_BIT] || !st.engine_running;
   assign man_open_inh = st.manual_mode && !st.breaker_closed && !ctrl_q[CTRL_MAN_EN_BIT];

   assign cond[SRC_GEN0] = meas.v_min < gen_thr_q[0];
   assign armed[SRC_GEN0] = !gen_inh && !st.ride_through && vf_seen_q &&
                            !man_open_inh;
   assign cond[SRC_GEN0 + 1] = meas.v_max > gen_thr_q[1];
   assign armed[SRC_GEN0 + 1] = !gen_inh;
   assign cond[SRC_GEN0 + 2] = meas.freq < gen_thr_q[2];
   assign armed[SRC_GEN0 + 2] = !gen_inh && vf_seen_q && !man_open_inh;
   assign cond[SRC_GEN0 + 3] = meas.freq > gen_thr_q[3];
   assign armed[SRC_GEN0 + 3] = !gen_inh;
   assign code[SRC_GEN0] = CODE_MIN_V;
   assign code[SRC_GEN0 + 1] = CODE_MAX_V;
   assign code[SRC_GEN0 + 2] = CODE_MIN_F;
   assign code[SRC_GEN0 + 3] = CODE_MAX_F;
   assign cls[SRC_GEN0] = GSAM_DEACT;
   assign cls[SRC_GEN0 + 1] = GSAM_ALARM;
   assign cls[SRC_GEN0 + 2] = GSAM_DEACT;
   assign cls[SRC_GEN0 + 3] = GSAM_ALARM;

   for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
      assign dly[SRC_GEN0 + g] = gen_dly_q[g];
      assign ovr_mask[SRC_GEN0 + g] = OVR_F | OVR_G;
      assign high_mk[SRC_GEN0 + g] = (g % 2 == 1);
      assign builtin[SRC_GEN0 + g] = 1'b1;
      assign pump_grp[SRC_GEN0 + g] = 1'b0;
   end

   // per-source activation delay and override downgrade
   for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            cnt_q[s] <= '0;
            active_q[s] <= 1'b0;
         end else if (!(cond[s] && armed[s]) || dly[s] == '0) begin
            cnt_q[s] <= '0;
            active_q[s] <= 1'b0;
         end else if (tick_q && !active_q[s]) begin
            cnt_q[s] <= cnt_q[s] + 16'h0001;
            active_q[s] <= (cnt_q[s] + 16'h0001 >= dly[s]);
         end
      end
      assign eff_cls[s] = |(ovr_mask[s] & ovr_req) ? GSAM_WARNING : cls[s];
   end

   // report queue: a new activation in the cycle its bit is reported still wins
   logic [NUM_SRC-1:0] rise, pick;
   assign rise = active_q & ~active_dly_q;
   assign pick = pending_q & (~pending_q + 16'h0001);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         active_dly_q <= '0;
         pending_q <= '0;
      end else begin
         active_dly_q <= active_q;
         pending_q <= (pending_q & ~pick) | rise;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         report <= '0;
      end else begin
         report <= '0;
         for (int s = 0; s < NUM_SRC; s++) begin
            if (pick[s]) begin
               report.valid <= 1'b1;
               report.code <= code[s];
               report.cls <= gsam_class_e'(eff_cls[s]);
               report.high_marker <= high_mk[s];
               report.builtin_msg <= builtin[s];
            end
         end
      end
   end

   // summaries and pump stop, one cycle behind the active flags
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         anomaly_active <= '0;
         any_warning <= 1'b0;
         any_deact <= 1'b0;
         any_unload <= 1'b0;
         any_alarm <= 1'b0;
         fuel_pump_stop <= 1'b0;
      end else begin
         anomaly_active <= active_q;
         any_warning <= 1'b0;
         any_deact <= 1'b0;
         any_unload <= 1'b0;
         any_alarm <= 1'b0;
         for (int s = 0; s < NUM_SRC; s++) begin
            if (active_q[s]) begin
               case (eff_cls[s])
                  GSAM_WARNING: any_warning <= 1'b1;
                  GSAM_DEACT: any_deact <= 1'b1;
                  GSAM_UNLOAD: any_unload <= 1'b1;
                  default: any_alarm <= 1'b1;
               endcase
            end
         end
         fuel_pump_stop <= |(active_q & pump_grp);
      end
   end

endmodule : gsam_core

// *** bench/gsam_genset_model.sv ***
// gsam_genset_model: far side of the anomaly manager, the contacts and measures.
// assumes the bench sets levels; the model launches them just after each edge.
`timescale 1ns/10ps
module gsam_genset_model
   import gsam_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [NUM_DIN-1:0] set_din,
   input wire gsam_status_s set_status,
   input wire gsam_meas_s set_meas,
   output logic [NUM_DIN-1:0] din_pin,
   output gsam_status_s status_pin,
   output gsam_meas_s meas
);
   // contacts carry no timing of their own, so the far side is a plain register
   initial begin
      din_pin = '0;
      status_pin = '0;
      meas = '0;
   end
   always @(posedge ref_clk) begin
      din_pin <= set_din;
      status_pin <= set_status;
      meas <= set_meas;
   end
endmodule : gsam_genset_model

// *** bench/gsam_monitor.sv ***
// gsam_monitor: port-level checks of the anomaly manager.
// assumes it is bound into gsam_core and sees only its ports.
`timescale 1ns/10ps
module gsam_monitor
   import gsam_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire gsam_status_s status_pin,
   input wire logic [NUM_SRC-1:0] anomaly_active,
   input wire gsam_report_s report
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic [CODE_W-1:0] c;
   logic v;
   assign c = report.code;
   assign v = report.valid;
   property p_rd_slot; !$past(reg_rd) |-> reg_rdata == '0; endproperty
   a_rd_slot: assert property (p_rd_slot) else $error("read data outside its slot");
   property p_minv; v && c == CODE_MIN_V |-> !report.high_marker && report.builtin_msg
      && report.cls inside {GSAM_DEACT, GSAM_WARNING}; endproperty
   a_minv: assert property (p_minv) else $error("min voltage report");
   property p_maxv; v && c == CODE_MAX_V |-> report.high_marker
      && report.cls inside {GSAM_ALARM, GSAM_WARNING}; endproperty
   a_maxv: assert property (p_maxv) else $error("max voltage report");
   property p_minf; v && c == CODE_MIN_F |-> !report.high_marker
      && report.cls inside {GSAM_DEACT, GSAM_WARNING}; endproperty
   a_minf: assert property (p_minf) else $error("min frequency report");
   property p_maxf; v && c == CODE_MAX_F |-> report.high_marker
      && report.cls inside {GSAM_ALARM, GSAM_WARNING}; endproperty
   a_maxf: assert property (p_maxf) else $error("max frequency report");
   property p_spec; v && c >= CODE_SPECIFIC_BASE |-> report.builtin_msg; endproperty
   a_spec: assert property (p_spec) else $error("specific report lacks message");
   // a stopped engine must clear every generator protection within six clocks
   property p_stop; !status_pin.engine_running [*6] |->
      anomaly_active[NUM_SRC-1:SRC_GEN0] == '0; endproperty
   a_stop: assert property (p_stop) else $error("protection active when stopped");
   property p_rep; (anomaly_active & ~$past(anomaly_active)) != '0 |-> ##[1:17] v; endproperty
   a_rep: assert property (p_rep) else $error("activation not reported");
   c_warn: cover property (v && report.cls == GSAM_WARNING);
   c_high: cover property (v && report.high_marker);
   c_gen: cover property (anomaly_active[NUM_SRC-1]);
endmodule : gsam_monitor
bind gsam_core gsam_monitor gsam_monitor_i (.ref_clk(ref_clk), .nrst(nrst), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .status_pin(status_pin), .anomaly_active(anomaly_active),
   .report(report));

// *** bench/test_genset_anomaly_manager.sv ***
// test_genset_anomaly_manager: register and anomaly sequences for gsam_core.
// assumes gsam_genset_model drives the pins; the tick is cut to 4 clocks.
`timescale 1ns/10ps
module test_genset_anomaly_manager
   import gsam_pkg::*;
;
   localparam int FN[8] = '{4001, 4002, 4003, 4004, 4054, 4211, 4062, 4001};
   localparam int CD[7] = '{701, 722, 729, 746, 689, 900, 707};
   localparam logic [1:0] CL[7] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2, 2'h1};
   localparam int GT[4] = '{1000, 1000, 500, 100};
   logic ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, rd_v;
   logic [NUM_DIN-1:0] set_din = '0, din_pin;
   gsam_status_s set_status = '0, status_pin;
   gsam_meas_s set_meas = '0, meas;
   logic [NUM_SRC-1:0] anomaly_active;
   gsam_report_s report;
   logic any_warning, any_deact, any_unload, any_alarm, fuel_pump_stop;
   int bad_count = 0, checks_done = 0;
   logic [12:0] exp_q[$];
   gsam_genset_model gsam_genset_model_i (.ref_clk(ref_clk), .set_din(set_din),
      .set_status(set_status), .set_meas(set_meas), .din_pin(din_pin),
      .status_pin(status_pin), .meas(meas));
   gsam_core #(.TICK_CYCLES(4)) gsam_core_i (.ref_clk(ref_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .din_pin(din_pin), .status_pin(status_pin), .meas(meas),
      .anomaly_active(anomaly_active), .report(report), .any_warning(any_warning),
      .any_deact(any_deact), .any_unload(any_unload), .any_alarm(any_alarm),
      .fuel_pump_stop(fuel_pump_stop));
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   task give_verdict;
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict
   task check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask : rd
   // waits for the expected reports, then lingers so a stray one is caught
   task drain;
      for (int n = 0; n < 300 && exp_q.size() > 0; n++) @(posedge ref_clk);
      repeat (20) @(posedge ref_clk);
      check(16'(exp_q.size()), 16'h0);
   endtask : drain
   always @(posedge ref_clk) begin
      if (report.valid === 1'b1) begin
         if (exp_q.size() == 0) check(16'h1, 16'h0);
         else check({3'h0, report.code, report.cls, report.high_marker},
            {3'h0, exp_q.pop_front()});
      end
   end
   initial begin
      #200000;
      bad_count++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(REG_OIL_DLY);
      check(rd_v[15:0], 16'h0);
      wr(REG_ACTIVE, 32'h5);
      rd(REG_ACTIVE);
      check(rd_v[15:0], 16'h0);
      rd(8'h30);
      check(rd_v[15:0], 16'h0);
      set_status.engine_running <= 1'b1;
      set_status.vf_ok <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(REG_DIN_CFG0 + 8'(i), 32'((i << 16) | ((i < 5 ? i : 0) << 13) | FN[i]));
         wr(REG_DIN_DLY0 + 8'(i), i == 7 ? 32'h3 : 32'h1);
      end
      rd(REG_DIN_DLY0 + 8'h7);
      check(rd_v[15:0], 16'h3);
      set_din <= 8'h80;
      repeat (6) @(posedge ref_clk);
      set_din <= 8'h00;
      drain();
      for (int i = 0; i < 7; i++) exp_q.push_back({10'(CD[i]), CL[i], 1'b0});
      set_din <= 8'h7F;
      drain();
      check(anomaly_active, 16'h007F);
      check({any_alarm, any_unload, any_deact, any_warning}, 16'hF);
      check(fuel_pump_stop, 16'h1);
      set_din <= 8'h00;
      repeat (20) @(posedge ref_clk);
      check(fuel_pump_stop, 16'h0);
      set_status.ovr_full <= 1'b1;
      set_meas.v_max <= 16'h07D0;
      set_meas.freq <= 16'h012C;
      for (int i = 0; i < 4; i++) wr(REG_GEN_THR0 + 8'(i), 32'(GT[i]));
      for (int i = 0; i < 4; i++) begin
         exp_q.push_back({10'(i + 1), GSAM_WARNING, 1'(i % 2)});
         wr(REG_GEN_DLY0 + 8'(i), 32'h1);
      end
      drain();
      check(anomaly_active[15:12], 16'hF);
      wr(REG_GEN_DLY0, 32'h0);
      repeat (4) @(posedge ref_clk);
      check(anomaly_active[12], 16'h0);
      set_meas.ain[0] <= 16'h0064;
      wr(REG_AIN_THR0, 32'h32);
      wr(REG_AIN_THR0 + 8'h1, 32'hC8);
      exp_q.push_back({10'h12E, GSAM_ALARM, 1'b1});
      exp_q.push_back({10'h12D, GSAM_ALARM, 1'b0});
      wr(REG_AIN_CFG0, 32'h10001);
      wr(REG_AIN_CFG0 + 8'h1, 32'h1);
      drain();
      check(anomaly_active[11:8], 16'h3);
      wr(REG_CTRL, 32'h1);
      repeat (4) @(posedge ref_clk);
      check(anomaly_active[15:13], 16'h0);
      rd(REG_SUMMARY);
      check(rd_v[15:0], 16'h0008);
      give_verdict();
   end
endmodule : test_genset_anomaly_manager
